// ==== rtl/scp_pkg.sv ====
package scp_pkg;

    // datagram geometry
    localparam int unsigned DGRAM_W      = 40;
    localparam int unsigned CNT_W        = 6;
    localparam int unsigned WR_BIT       = 39;
    localparam int unsigned STAT_HI      = 39;
    localparam int unsigned STAT_LO      = 32;
    localparam int unsigned STAT_W       = 8;
    localparam int unsigned DATA_W       = 32;
    localparam int unsigned ADDR_W       = 7;

    // timing
    localparam int unsigned CLK_MHZ      = 50;
    localparam int unsigned FILT_NS      = 20;
    // pulses shorter than the filter time are rejected: round up, at least one cycle
    localparam int unsigned FILT_CYC_RAW = (FILT_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned FILT_CYC     = (FILT_CYC_RAW < 1) ? 1 : FILT_CYC_RAW;
    localparam int unsigned FILT_W       = 3;

    // fifo
    localparam int unsigned FIFO_DEPTH   = 8;

    localparam logic [DGRAM_W-1:0] DGRAM_RST = 40'h00_0000_0000;
    localparam logic [CNT_W-1:0]   CNT_ZERO  = 6'h00;
    localparam logic [CNT_W-1:0]   CNT_FULL  = 6'h28;

    // one command taken at select rise
    typedef struct packed {
        logic              wr;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } scp_cmd_t;

    // reply source supplied by the register side
    typedef struct packed {
        logic [STAT_W-1:0] status;
        logic [DATA_W-1:0] rdata;
    } scp_reply_t;

    // pin view, used for the raw, synchronised and filtered copies
    typedef struct packed {
        logic sck;
        logic sel_n;
        logic sdi;
        logic drv_en_n;
    } scp_pins_t;

endpackage

// ==== rtl/scp_fifo.sv ====
`timescale 1ns/1ps
module scp_fifo #(
    parameter int unsigned WIDTH = 40,
    parameter int unsigned DEPTH = 8
) (
    // clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_rst,
    // fill side
    input  wire logic             i_valid,
    output logic                  o_ready,
    input  wire logic [WIDTH-1:0] i_data,
    // drain side
    output logic                  o_valid,
    input  wire logic             i_ready,
    output logic      [WIDTH-1:0] o_data
);
    localparam int unsigned AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wp;
        logic [AW-1:0]               rp;
        logic [AW:0]                 cnt;
    } scp_fifo_st_t;

    scp_fifo_st_t st_q;
    scp_fifo_st_t st_d;
    logic         push;
    logic         pop;

    assign o_ready = (st_q.cnt != DEPTH[AW:0]);
    assign o_valid = (st_q.cnt != '0);
    assign o_data  = st_q.mem[st_q.rp];
    assign push    = i_valid && o_ready;
    assign pop     = o_valid && i_ready;

    always_comb begin
        st_d = st_q;
        if (push) begin
            st_d.mem[st_q.wp] = i_data;
            st_d.wp           = (st_q.wp == AW'(DEPTH - 1)) ? '0 : st_q.wp + 1'b1;
        end
        if (pop) begin
            st_d.rp = (st_q.rp == AW'(DEPTH - 1)) ? '0 : st_q.rp + 1'b1;
        end
        if (push && !pop) begin
            st_d.cnt = st_q.cnt + 1'b1;
        end else if (pop && !push) begin
            st_d.cnt = st_q.cnt - 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end
endmodule

// ==== rtl/scp_port.sv ====
`timescale 1ns/1ps
// What this block does
// [R1] select high: shift clock ignored
// [R2] capture on rising, drive after falling
// [R3] datagram shifted most significant bit first
// [R4] host gives at least 40 clocks
// [R5] extra bits emerge 40 clocks later
// [R6] host holds select low throughout
// [R7] select rise latches command and executes
// [R8] only last 40 bits form command
// [R9] host keeps clock below half system
// [R10] on-chip oscillator needs further 10% margin
// [R11] pulses under 20ns are filtered out
// [R12] host limits clock to 4/8 MHz
// [R13] mode 3: idle high, rising capture
// [R14] bit 39 set means write
// [R15] reply carries previous read or write data
// [R16] status byte fills bits 39 to 32
// [R17] status latched at each access end
// [R18] pins synchronised, edges found internally
// [R19] output released while select high
module scp_port
    import scp_pkg::*;
#(
    parameter int unsigned FILT_CYCLES = scp_pkg::FILT_CYC
) (
    // clock and reset
    input  wire logic                       i_clk,
    input  wire logic                       i_rst,
    // serial pins
    input  wire logic                       i_sck,
    input  wire logic                       i_select_low_in,
    input  wire logic                       i_sdi,
    input  wire logic                       i_driver_enable_low_in,
    output logic                            o_sdo,
    output logic                            o_sdo_oe,
    // filtered driver enable
    output logic                            o_driver_enable_low,
    // command stream
    output logic                            o_cmd_valid,
    input  wire logic                       i_cmd_ready,
    output scp_pkg::scp_cmd_t               o_cmd,
    // reply source
    input  wire scp_pkg::scp_reply_t        i_reply,
    output logic                            o_reply_take,
    // transaction shortfall pulse
    output logic                            o_short_frame
);
    ////////////////////////////////////////////////////////////////////////////
    // synchroniser and glitch filter

    typedef struct packed {
        scp_pins_t                  s1;
        scp_pins_t                  s2;
        scp_pins_t                  flt;
        logic [3:0][FILT_W-1:0]     fcnt;
        logic [DGRAM_W-1:0]         sh;
        logic [CNT_W-1:0]           bits;
        logic                       sdo;
        logic                       oe;
        logic                       cmd_push;
        scp_cmd_t                   cmd;
        logic                       short_p;
        logic                       take;
    } scp_st_t;

    scp_st_t   st_q;
    scp_st_t   st_d;
    scp_pins_t raw;
    logic      sck_rise;
    logic      sck_fall;
    logic      sel_rise;
    logic      sel_fall;
    logic      fifo_ready;
    scp_pins_t flt_upd;

    assign raw = '{sck: i_sck, sel_n: i_select_low_in, sdi: i_sdi,
                   drv_en_n: i_driver_enable_low_in};

    // a new level must show on FILT_CYCLES+1 samples one period apart,
    // so a pulse shorter than one period can never pass
    for (genvar g = 0; g < 4; g++) begin : g_flt_upd
        assign flt_upd[g] = (st_q.s2[g] != st_q.flt[g]) &&
                            (st_q.fcnt[g] >= FILT_W'(FILT_CYCLES));   // [R11]
    end

    // edges only from filtered copies, never from first stage; built from
    // registered state alone, so no loop through the next-state copy
    assign sck_rise = flt_upd.sck && st_q.s2.sck;
    assign sck_fall = flt_upd.sck && !st_q.s2.sck;
    assign sel_rise = flt_upd.sel_n && st_q.s2.sel_n;
    assign sel_fall = flt_upd.sel_n && !st_q.s2.sel_n;

    function automatic logic [DGRAM_W-1:0] shift_in(input logic [DGRAM_W-1:0] v,
                                                    input logic b);
        shift_in = {v[DGRAM_W-2:0], b};
    endfunction

    always_comb begin
        st_d          = st_q;
        st_d.s1       = raw;
        st_d.s2       = st_q.s1;                               // [R18]
        st_d.cmd_push = 1'b0;
        st_d.short_p  = 1'b0;
        st_d.take     = 1'b0;
        // each filtered line follows only after a stable run
        for (int i = 0; i < 4; i++) begin
            if (st_q.s2[i] == st_q.flt[i]) begin
                st_d.fcnt[i] = '0;
            end else if (flt_upd[i]) begin
                st_d.flt[i]  = st_q.s2[i];                     // [R11]
                st_d.fcnt[i] = '0;
            end else begin
                st_d.fcnt[i] = st_q.fcnt[i] + 1'b1;
            end
        end

        ////////////////////////////////////////////////////////////////////////
        // shifting and command latch

        if (sel_fall) begin
            st_d.bits = CNT_ZERO;
            st_d.oe   = 1'b1;
            st_d.sdo  = st_q.sh[DGRAM_W-1];                    // [R3]
        end
        if (!st_d.flt.sel_n && !sel_fall) begin               // [R1] [R13]
            if (sck_rise) begin
                st_d.sh = shift_in(st_q.sh, st_q.flt.sdi);     // [R2] [R5]
                if (st_q.bits != CNT_FULL) begin
                    st_d.bits = st_q.bits + 1'b1;
                end
            end
            if (sck_fall) begin
                st_d.sdo = st_q.sh[DGRAM_W-1];                 // [R2] [R3] [R5]
            end
        end
        if (sel_rise) begin
            st_d.oe = 1'b0;                                    // [R19]
            if (st_q.bits == CNT_FULL) begin
                // last 40 bits are whatever sits in the register
                st_d.cmd.wr   = st_q.sh[WR_BIT];               // [R7] [R8] [R14]
                st_d.cmd.addr = st_q.sh[WR_BIT-1 -: ADDR_W];
                st_d.cmd.data = st_q.sh[DATA_W-1:0];
                st_d.cmd_push = 1'b1;
                st_d.take     = 1'b1;
                // reply for next frame: status snapshot plus echo or read data
                st_d.sh[STAT_HI:STAT_LO] = i_reply.status;     // [R16] [R17]
                st_d.sh[DATA_W-1:0] = st_q.sh[WR_BIT] ? st_q.sh[DATA_W-1:0]
                                                      : i_reply.rdata;  // [R15]
            end else begin
                st_d.short_p = 1'b1;                           // [R4]
            end
        end
        if (st_q.cmd_push && !fifo_ready) begin
            st_d.cmd_push = 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st_q      <= '0;
            st_q.s1   <= '{sck: 1'b1, sel_n: 1'b1, sdi: 1'b0, drv_en_n: 1'b1};
            st_q.s2   <= '{sck: 1'b1, sel_n: 1'b1, sdi: 1'b0, drv_en_n: 1'b1};
            st_q.flt  <= '{sck: 1'b1, sel_n: 1'b1, sdi: 1'b0, drv_en_n: 1'b1};
            st_q.sh   <= DGRAM_RST;
            st_q.bits <= CNT_ZERO;
        end else begin
            st_q <= st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // command buffer; a full buffer drops the command, the host sees no sign

    scp_fifo #(
        .WIDTH ($bits(scp_cmd_t)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_valid (st_q.cmd_push),
        .o_ready (fifo_ready),
        .i_data  (st_q.cmd),
        .o_valid (o_cmd_valid),
        .i_ready (i_cmd_ready),
        .o_data  (o_cmd)
    );

    assign o_sdo               = st_q.sdo;
    assign o_sdo_oe            = st_q.oe;
    assign o_driver_enable_low = st_q.flt.drv_en_n;
    assign o_reply_take        = st_q.take;
    assign o_short_frame       = st_q.short_p;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    sequence s_sel_rise_full;
        sel_rise && (st_q.bits == CNT_FULL);
    endsequence

    AST_OE_OFF_IDLE: assert property (@(posedge i_clk) disable iff (i_rst) // [R19]
        st_q.flt.sel_n && !sel_fall |=> !o_sdo_oe)
        else $error("sdo driven while select high");

    AST_CMD_AT_RISE: assert property (@(posedge i_clk) disable iff (i_rst) // [R7]
        s_sel_rise_full |=> st_q.take ##1 !st_q.take)
        else $error("command not taken at select rise");

    AST_CMD_BITS: assert property (@(posedge i_clk) disable iff (i_rst) // [R8]
        s_sel_rise_full |=> st_q.cmd.data == $past(st_q.sh[DATA_W-1:0]))
        else $error("command data not last bits");

    AST_WR_BIT: assert property (@(posedge i_clk) disable iff (i_rst) // [R14]
        s_sel_rise_full |=> st_q.cmd.wr == $past(st_q.sh[WR_BIT]))
        else $error("write bit wrong");

    AST_IGNORE_SCK: assert property (@(posedge i_clk) disable iff (i_rst) // [R1]
        st_q.flt.sel_n && st_d.flt.sel_n |=> $stable(st_q.sh))
        else $error("shift while deselected");

    AST_SHIFT_MSB: assert property (@(posedge i_clk) disable iff (i_rst) // [R2]
        !st_d.flt.sel_n && !sel_fall && sck_rise
        |=> st_q.sh == {$past(st_q.sh[DGRAM_W-2:0]), $past(st_q.flt.sdi)})
        else $error("bad capture");

    AST_SDO_FALL: assert property (@(posedge i_clk) disable iff (i_rst) // [R3]
        !st_d.flt.sel_n && !sel_fall && sck_fall |=> o_sdo == $past(st_q.sh[DGRAM_W-1]))
        else $error("sdo not msb after falling edge");

    AST_STATUS: assert property (@(posedge i_clk) disable iff (i_rst) // [R16]
        s_sel_rise_full |=> st_q.sh[STAT_HI:STAT_LO] == $past(i_reply.status))
        else $error("status byte not loaded");

    AST_ECHO: assert property (@(posedge i_clk) disable iff (i_rst) // [R15]
        (s_sel_rise_full and st_q.sh[WR_BIT]) |=> st_q.sh[DATA_W-1:0] == st_q.cmd.data)
        else $error("write not echoed");

    AST_SHORT: assert property (@(posedge i_clk) disable iff (i_rst) // [R4]
        sel_rise && (st_q.bits != CNT_FULL) |=> o_short_frame && !st_q.take)
        else $error("short frame not flagged");

    ////////////////////////////////////////////////////////////////////////////
    // checks on framing, counting, reply loading and the filter

    // a frame that ended early
    sequence s_sel_rise_short;
        sel_rise && (st_q.bits != CNT_FULL);
    endsequence

    // one captured bit while the frame is open
    sequence s_shift_edge;
        !st_d.flt.sel_n && !sel_fall && sck_rise;
    endsequence

    AST_SEL_FALL_OUT: assert property (@(posedge i_clk) disable iff (i_rst) // [R3] [R19]
        sel_fall |=> o_sdo_oe && (o_sdo == $past(st_q.sh[DGRAM_W-1])))
        else $error("first reply bit not shown at select fall");

    AST_OE_WHILE_SEL: assert property (@(posedge i_clk) disable iff (i_rst) // [R19]
        !st_q.flt.sel_n |-> o_sdo_oe)
        else $error("sdo released inside a frame");

    AST_SDO_HOLD: assert property (@(posedge i_clk) disable iff (i_rst) // [R2]
        !st_d.flt.sel_n && !sel_fall && !sck_fall |=> $stable(o_sdo))
        else $error("sdo moved without a falling shift clock");

    AST_CNT_RESTART: assert property (@(posedge i_clk) disable iff (i_rst) // [R4]
        sel_fall |=> st_q.bits == CNT_ZERO)
        else $error("bit count not cleared at select fall");

    AST_CNT_STEP: assert property (@(posedge i_clk) disable iff (i_rst) // [R4]
        (s_shift_edge and (st_q.bits != CNT_FULL)) |=> st_q.bits == $past(st_q.bits) + 1'b1)
        else $error("bit count did not advance");

    AST_CNT_SAT: assert property (@(posedge i_clk) disable iff (i_rst) // [R8]
        (s_shift_edge and (st_q.bits == CNT_FULL)) |=> st_q.bits == CNT_FULL)
        else $error("bit count left its ceiling");

    AST_SHORT_KEEP: assert property (@(posedge i_clk) disable iff (i_rst) // [R4]
        s_sel_rise_short |=> $stable(st_q.sh) && !st_q.cmd_push && !o_reply_take)
        else $error("short frame disturbed the reply or pushed a command");

    AST_SHORT_PULSE: assert property (@(posedge i_clk) disable iff (i_rst) // [R4]
        o_short_frame |=> !o_short_frame)
        else $error("short frame flag longer than one cycle");

    AST_CMD_PUSH: assert property (@(posedge i_clk) disable iff (i_rst) // [R7]
        s_sel_rise_full
        |=> st_q.cmd_push && (st_q.cmd.addr == $past(st_q.sh[WR_BIT-1 -: ADDR_W])))
        else $error("command not pushed with its address");

    AST_READ_DATA: assert property (@(posedge i_clk) disable iff (i_rst) // [R15]
        (s_sel_rise_full and !st_q.sh[WR_BIT])
        |=> st_q.sh[DATA_W-1:0] == $past(i_reply.rdata))
        else $error("read data not loaded for the next frame");

    // the filtered copy only takes a level seen on the last two samples,
    // and that level has come through both synchroniser stages
    for (genvar g = 0; g < 4; g++) begin : g_flt_chk
        AST_FILT_TWO: assert property (@(posedge i_clk) disable iff (i_rst) // [R11]
            $changed(st_q.flt[g])
            |-> ($past(st_q.s2[g]) == st_q.flt[g]) && ($past(st_q.s2[g], 2) == st_q.flt[g]))
            else $error("filter passed a one-sample pulse");

        AST_SYNC_PATH: assert property (@(posedge i_clk) disable iff (i_rst) // [R18]
            $changed(st_q.flt[g]) |-> $past(st_q.s1[g], 2) == st_q.flt[g])
            else $error("filtered level skipped the synchroniser");
    end
endmodule

// ==== verification/scp_host_model.sv ====
`timescale 1ns/1ps
module scp_host_model (
    // system clock, used only to pace the link
    input  wire logic i_clk,
    // link pins
    input  wire logic i_sdo,
    output logic      o_sck,
    output logic      o_sel_n,
    output logic      o_sdi
);
    // 4 system clocks per half period: 160 ns period, under half the system rate
    localparam int HALF = 4;

    initial begin
        o_sck   = 1'b1;
        o_sel_n = 1'b1;
        o_sdi   = 1'b0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(negedge i_clk);
    endtask

    // sdo read at end of high phase, where it has long settled
    task automatic xfer(input logic [79:0] tx, input int n, output logic [79:0] rx);
        rx = '0;
        o_sel_n = 1'b0;
        wait_clk(2 * HALF);
        for (int i = n - 1; i >= 0; i--) begin
            o_sck = 1'b0;
            o_sdi = tx[i];
            wait_clk(HALF);
            o_sck = 1'b1;
            wait_clk(HALF);
            rx = {rx[78:0], i_sdo};
        end
        o_sel_n = 1'b1;
        // released line must not keep showing the last bit
        o_sdi = ~o_sdi;
    endtask

    task automatic idle_clocks(input int n);
        repeat (n) begin
            o_sck = 1'b0;
            wait_clk(HALF);
            o_sck = 1'b1;
            wait_clk(HALF);
        end
    endtask
endmodule

// ==== verification/spi_serial_command_port_test.sv ====
`timescale 1ns/1ps
module spi_serial_command_port_test;
    import scp_pkg::*;
    logic        i_clk = 1'b0;
    logic        i_rst;
    logic        sck, sel_low, sdi, sdo, sdo_oe, sdo_line;
    logic        drv_en_low_in;
    logic        drv_en_low, cmd_valid, reply_take, short_frame;
    logic        cmd_ready;
    scp_cmd_t    cmd;
    scp_reply_t  reply;
    logic [39:0] cmd_q[$];
    bit          ev_q[$];
    logic [39:0] exp_rep = '0;
    bit          known = 1'b1;
    bit          rdy_en = 1'b1;
    bit          sel_q = 1'b1;
    int          occ, sel_cnt, bad_count, n_compared;

    always #10 i_clk = ~i_clk;

    // a released sdo floats up to its pull-up
    assign sdo_line = sdo_oe ? sdo : 1'b1;

    scp_port dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_sck(sck), .i_select_low_in(sel_low),
        .i_sdi(sdi), .i_driver_enable_low_in(drv_en_low_in), .o_sdo(sdo), .o_sdo_oe(sdo_oe),
        .o_driver_enable_low(drv_en_low), .o_cmd_valid(cmd_valid), .i_cmd_ready(cmd_ready),
        .o_cmd(cmd), .i_reply(reply), .o_reply_take(reply_take), .o_short_frame(short_frame));

    scp_host_model host_u (.i_clk(i_clk), .i_sdo(sdo_line), .o_sck(sck), .o_sel_n(sel_low),
        .o_sdi(sdi));

    task automatic cmp(input string what, input logic [39:0] exp, input logic [39:0] got);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    function automatic logic [39:0] rnd(input bit wr);
        return {wr, 7'($urandom), 32'($urandom)};
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // one frame; notes the reply due next time and the command due out
    task automatic frame(input logic [79:0] tx, input int n);
        logic [79:0] rx;
        scp_reply_t  r;
        r.status = 8'($urandom);
        r.rdata  = $urandom;
        reply    = r;
        host_u.xfer(tx, n, rx);
        if (known && n >= 40) cmp("reply", exp_rep, rx[n-1 -: 40]);
        if (known && n < 40) cmp("reply_part", exp_rep >> (40 - n), rx[39:0]);
        if (n == 80) cmp("chain", tx[79:40], rx[39:0]);
        // a short frame leaves the shift register undefined for us
        known = (n >= 40);
        ev_q.push_back(known);
        if (known && occ < 8) begin
            cmd_q.push_back(tx[39:0]);
            occ++;
        end
        if (known) exp_rep = {r.status, tx[39] ? tx[31:0] : r.rdata};
        host_u.wait_clk(10);
    endtask

    always @(negedge i_clk) cmd_ready <= rdy_en & 1'($urandom);

    ////////////////////////////////////////////////////////////////////////////////
    // watcher: takes the oldest note whenever a result shows
    always @(posedge i_clk) begin
        if (!i_rst) begin
            if (cmd_valid && cmd_ready) begin
                cmp("cmd", cmd_q.size() ? cmd_q.pop_front() : 40'hx, cmd);
                occ--;
            end
            if (reply_take || short_frame)
                cmp("frame", ev_q.size() ? ev_q.pop_front() : 1'bx, reply_take);
            sel_cnt = (sel_low == sel_q) ? sel_cnt + 1 : 0;
            sel_q = sel_low;
            if (sel_cnt == 8) cmp("sdo_oe", !sel_low, sdo_oe);
        end
    end

    initial begin
        repeat (60000) @(posedge i_clk);
        bad_count++;
        tally_and_finish();
    end

    initial begin
        void'($urandom(36469));
        i_rst         = 1'b1;
        drv_en_low_in = 1'b1;
        repeat (6) @(negedge i_clk);
        i_rst = 1'b0;
        host_u.wait_clk(6);
        for (int k = 0; k < 12; k++) frame({40'h0, rnd(k[0])}, 40);
        host_u.idle_clocks(20);
        frame({40'h0, rnd(1'b1)}, 40);
        frame({40'h0, rnd(1'b0)}, 20);
        frame({40'h0, rnd(1'b1)}, 40);
        frame({rnd(1'b1), rnd(1'b0)}, 80);
        // stall the consumer once drained: the ninth command has no room
        wait (occ == 0);
        rdy_en = 1'b0;
        host_u.wait_clk(20);
        repeat (9) frame({40'h0, rnd(1'b1)}, 40);
        rdy_en = 1'b1;
        host_u.wait_clk(100);
        cmp("left", 40'h0, 40'(cmd_q.size()));
        cmp("events_left", 40'h0, 40'(ev_q.size()));
        drv_en_low_in = 1'b0;
        host_u.wait_clk(6);
        cmp("drv_en", 40'h0, drv_en_low);
        drv_en_low_in = 1'b1;
        host_u.wait_clk(6);
        cmp("drv_en", 40'h1, drv_en_low);
        // a 4 ns dip across one sampling edge must never reach the output
        #8 drv_en_low_in = 1'b0;
        #4 drv_en_low_in = 1'b1;
        repeat (6) begin
            host_u.wait_clk(1);
            cmp("drv_glitch", 40'h1, drv_en_low);
        end
        tally_and_finish();
    end
endmodule
